// file: rtl/srls_link_status.sv
// Top of the per-lane link status block: three lane status registers
// (lanes 2, 3, 4) behind a read-only register port.
// Assumes lane flags, counts and threshold are synchronous to clk.
`timescale 1ns/10ps

// Operation
// - Bit 3: initial lane sync achieved
// - Bit 2: configuration checksum correct
// - Bit 1: frame sync achieved
// - Bit 0: code group sync achieved
// - Bit 7: disparity count at/above threshold
// - Bit 6: bad symbol count at/above threshold
// - Bit 5: stray control count at/above threshold
// - Bit 4: interlane deskew achieved
// - Lanes 3,4 at 0x4B3/0x4B4, reset 0, read-only
module srls_link_status
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Lane state, lanes 2..4 in index order
   input srls_pkg::srls_lane_in_s [2:0] laneIn,
   input wire logic [7:0] errorCountLimit,
   // Register read port
   input srls_pkg::srls_rd_req_s rdReq,
   output logic [7:0] rdData_q,
   output logic rdValid_q,
   output logic rdHit_q
);

   // ------------------------------------------------------------
   // Local sizes and lane slots
   // ------------------------------------------------------------
   localparam int unsigned AW = srls_pkg::ADDR_W;
   localparam int unsigned DW = srls_pkg::DATA_W;
   // Slot of each lane in the carrier and in the decode result
   localparam logic [1:0] SLOT_LANE2 = 2'h0;
   localparam logic [1:0] SLOT_LANE3 = 2'h1;
   localparam logic [1:0] SLOT_LANE4 = 2'h2;

   // ------------------------------------------------------------
   // Status byte helpers
   // ------------------------------------------------------------
   // One flag of a status byte
   function automatic logic flagAt(input logic [DW-1:0] status,
                                   input int unsigned pos);
      flagAt = status[pos];
   endfunction

   // Byte image of a lane from its named flags
   function automatic logic [DW-1:0] packStatus
   (
      input logic groupLocked,
      input logic frameLocked,
      input logic sumMatch,
      input logic alignSyncOk,
      input logic deskewOk,
      input logic strayOverLimit,
      input logic badSymbolOverLimit,
      input logic disparityOverLimit
   );
      packStatus = srls_pkg::LINK_STATUS_RESET;
      packStatus[srls_pkg::GROUP_LOCKED_BIT] = groupLocked;
      packStatus[srls_pkg::FRAME_LOCKED_BIT] = frameLocked;
      packStatus[srls_pkg::SUM_MATCH_BIT] = sumMatch;
      packStatus[srls_pkg::ALIGN_SYNC_BIT] = alignSyncOk;
      packStatus[srls_pkg::DESKEW_OK_BIT] = deskewOk;
      packStatus[srls_pkg::STRAY_CTRL_BIT] = strayOverLimit;
      packStatus[srls_pkg::BAD_SYMBOL_BIT] = badSymbolOverLimit;
      packStatus[srls_pkg::DISPARITY_BIT] = disparityOverLimit;
   endfunction

   // Read image of a decoded slot; unmapped reads as zero
   function automatic logic [DW-1:0] pickImage
   (
      input logic hit,
      input logic [1:0] slot,
      input logic [DW-1:0] lane2Image,
      input logic [DW-1:0] lane3Image,
      input logic [DW-1:0] lane4Image
   );
      pickImage = srls_pkg::UNMAPPED_READ;
      if (hit)
      begin
         case (slot)
            SLOT_LANE2: pickImage = lane2Image;
            SLOT_LANE3: pickImage = lane3Image;
            SLOT_LANE4: pickImage = lane4Image;
            default: pickImage = srls_pkg::UNMAPPED_READ;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Lane status registers
   // ------------------------------------------------------------
   srls_pkg::srls_lane_in_s lane2In;
   srls_pkg::srls_lane_in_s lane3In;
   srls_pkg::srls_lane_in_s lane4In;
   logic [DW-1:0] lane2Status;
   logic [DW-1:0] lane3Status;
   logic [DW-1:0] lane4Status;

   assign lane2In = laneIn[SLOT_LANE2];
   assign lane3In = laneIn[SLOT_LANE3];
   assign lane4In = laneIn[SLOT_LANE4];

   // Lane 2
   srls_lane_status u_lane2
   (
      .clk(clk),
      .rst_n(rst_n),
      .laneIn(lane2In),
      .errorCountLimit(errorCountLimit),
      .status_q(lane2Status)
   );

   // Lane 3
   srls_lane_status u_lane3
   (
      .clk(clk),
      .rst_n(rst_n),
      .laneIn(lane3In),
      .errorCountLimit(errorCountLimit),
      .status_q(lane3Status)
   );

   // Lane 4
   srls_lane_status u_lane4
   (
      .clk(clk),
      .rst_n(rst_n),
      .laneIn(lane4In),
      .errorCountLimit(errorCountLimit),
      .status_q(lane4Status)
   );

   // ------------------------------------------------------------
   // Named status flags
   // ------------------------------------------------------------
   // Lane 2
   logic lane2GroupLocked;
   logic lane2FrameLocked;
   logic lane2SumMatch;
   logic lane2AlignmentSyncOk;
   logic lane2DeskewOk;
   logic lane2StrayControlOverLimit;
   logic lane2BadSymbolOverLimit;
   logic lane2DisparityOverLimit;

   // Lane 3
   logic lane3GroupLocked;
   logic lane3FrameLocked;
   logic lane3SumMatch;
   logic lane3AlignmentSyncOk;
   logic lane3DeskewOk;
   logic lane3StrayControlOverLimit;
   logic lane3BadSymbolOverLimit;
   logic lane3DisparityOverLimit;

   // Lane 4
   logic lane4GroupLocked;
   logic lane4FrameLocked;
   logic lane4SumMatch;
   logic lane4AlignmentSyncOk;
   logic lane4DeskewOk;
   logic lane4StrayControlOverLimit;
   logic lane4BadSymbolOverLimit;
   logic lane4DisparityOverLimit;

   // Lane 2
   assign lane2GroupLocked =
      flagAt(lane2Status, srls_pkg::GROUP_LOCKED_BIT);
   assign lane2FrameLocked =
      flagAt(lane2Status, srls_pkg::FRAME_LOCKED_BIT);
   assign lane2SumMatch =
      flagAt(lane2Status, srls_pkg::SUM_MATCH_BIT);
   assign lane2AlignmentSyncOk =
      flagAt(lane2Status, srls_pkg::ALIGN_SYNC_BIT);
   assign lane2DeskewOk =
      flagAt(lane2Status, srls_pkg::DESKEW_OK_BIT);
   assign lane2StrayControlOverLimit =
      flagAt(lane2Status, srls_pkg::STRAY_CTRL_BIT);
   assign lane2BadSymbolOverLimit =
      flagAt(lane2Status, srls_pkg::BAD_SYMBOL_BIT);
   assign lane2DisparityOverLimit =
      flagAt(lane2Status, srls_pkg::DISPARITY_BIT);

   // Lane 3
   assign lane3GroupLocked =
      flagAt(lane3Status, srls_pkg::GROUP_LOCKED_BIT);
   assign lane3FrameLocked =
      flagAt(lane3Status, srls_pkg::FRAME_LOCKED_BIT);
   assign lane3SumMatch =
      flagAt(lane3Status, srls_pkg::SUM_MATCH_BIT);
   assign lane3AlignmentSyncOk =
      flagAt(lane3Status, srls_pkg::ALIGN_SYNC_BIT);
   assign lane3DeskewOk =
      flagAt(lane3Status, srls_pkg::DESKEW_OK_BIT);
   assign lane3StrayControlOverLimit =
      flagAt(lane3Status, srls_pkg::STRAY_CTRL_BIT);
   assign lane3BadSymbolOverLimit =
      flagAt(lane3Status, srls_pkg::BAD_SYMBOL_BIT);
   assign lane3DisparityOverLimit =
      flagAt(lane3Status, srls_pkg::DISPARITY_BIT);

   // Lane 4
   assign lane4GroupLocked =
      flagAt(lane4Status, srls_pkg::GROUP_LOCKED_BIT);
   assign lane4FrameLocked =
      flagAt(lane4Status, srls_pkg::FRAME_LOCKED_BIT);
   assign lane4SumMatch =
      flagAt(lane4Status, srls_pkg::SUM_MATCH_BIT);
   assign lane4AlignmentSyncOk =
      flagAt(lane4Status, srls_pkg::ALIGN_SYNC_BIT);
   assign lane4DeskewOk =
      flagAt(lane4Status, srls_pkg::DESKEW_OK_BIT);
   assign lane4StrayControlOverLimit =
      flagAt(lane4Status, srls_pkg::STRAY_CTRL_BIT);
   assign lane4BadSymbolOverLimit =
      flagAt(lane4Status, srls_pkg::BAD_SYMBOL_BIT);
   assign lane4DisparityOverLimit =
      flagAt(lane4Status, srls_pkg::DISPARITY_BIT);

   // ------------------------------------------------------------
   // Register images
   // ------------------------------------------------------------
   logic [DW-1:0] lane2Image;
   logic [DW-1:0] lane3Image;
   logic [DW-1:0] lane4Image;

   assign lane2Image = packStatus(lane2GroupLocked, lane2FrameLocked,
      lane2SumMatch, lane2AlignmentSyncOk, lane2DeskewOk,
      lane2StrayControlOverLimit, lane2BadSymbolOverLimit,
      lane2DisparityOverLimit);

   assign lane3Image = packStatus(lane3GroupLocked, lane3FrameLocked,
      lane3SumMatch, lane3AlignmentSyncOk, lane3DeskewOk,
      lane3StrayControlOverLimit, lane3BadSymbolOverLimit,
      lane3DisparityOverLimit);

   assign lane4Image = packStatus(lane4GroupLocked, lane4FrameLocked,
      lane4SumMatch, lane4AlignmentSyncOk, lane4DeskewOk,
      lane4StrayControlOverLimit, lane4BadSymbolOverLimit,
      lane4DisparityOverLimit);

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   logic rdTake;
   logic [AW-1:0] rdAddr;
   logic decHit;
   logic [1:0] decIdx;
   logic [DW-1:0] rdData_d;

   assign rdTake = rdReq.rdEn;
   assign rdAddr = rdReq.addr;

   srls_reg_decode u_dec
   (
      .addr(rdAddr),
      .hit(decHit),
      .laneIdx(decIdx)
   );

   // Unmapped addresses read as zero; nothing is cleared on read
   always_comb
   begin
      rdData_d = pickImage(decHit, decIdx, lane2Image, lane3Image,
         lane4Image);
   end

   // Answer strobe, one cycle after each taken read
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdValid_q <= 1'b0;
      else
         rdValid_q <= rdTake;
   end

   // Mapped-address flag, alongside the strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdHit_q <= 1'b0;
      else
         rdHit_q <= rdTake & decHit;
   end

   // Read data holds until the next taken read
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdData_q <= srls_pkg::LINK_STATUS_RESET;
      else
      begin
         if (rdTake)
            rdData_q <= rdData_d;
      end
   end

endmodule // srls_link_status

// file: rtl/srls_pkg.sv
// Package for the per-lane link status block: register map, bit
// positions, reset values and the lane input carrier.
// Assumes one clock domain shared with the lane receive logic.
package srls_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int unsigned NUM_LANES = 3;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 8;
   localparam logic [11:0] LANE2_LINK_STATUS_ADDR = 12'h04B2;
   localparam logic [11:0] LANE3_LINK_STATUS_ADDR = 12'h04B3;
   localparam logic [11:0] LANE4_LINK_STATUS_ADDR = 12'h04B4;
   localparam logic [7:0] LINK_STATUS_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ------------------------------------------------------------
   // Status bit positions
   // ------------------------------------------------------------
   localparam int unsigned GROUP_LOCKED_BIT = 0;
   localparam int unsigned FRAME_LOCKED_BIT = 1;
   localparam int unsigned SUM_MATCH_BIT = 2;
   localparam int unsigned ALIGN_SYNC_BIT = 3;
   localparam int unsigned DESKEW_OK_BIT = 4;
   localparam int unsigned STRAY_CTRL_BIT = 5;
   localparam int unsigned BAD_SYMBOL_BIT = 6;
   localparam int unsigned DISPARITY_BIT = 7;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic groupLocked;
      logic frameLocked;
      logic sumMatch;
      logic alignmentSyncOk;
      logic deskewOk;
      logic [7:0] disparityCount;
      logic [7:0] badSymbolCount;
      logic [7:0] strayControlCount;
   } srls_lane_in_s;

   typedef struct packed {
      logic rdEn;
      logic [11:0] addr;
   } srls_rd_req_s;

endpackage

// file: rtl/srls_lane_status.sv
// One lane's 8-bit link status register.
// Assumes sync flags and error counts come from the lane receiver
// in this clock domain.
`timescale 1ns/10ps
module srls_lane_status
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Lane state and threshold
   input srls_pkg::srls_lane_in_s laneIn,
   input wire logic [7:0] errorCountLimit,
   // Status register
   output logic [7:0] status_q
);

   // Count at or above the threshold
   function automatic logic overLimit(input logic [7:0] cnt,
                                      input logic [7:0] lim);
      overLimit = (cnt >= lim);
   endfunction

   logic [7:0] status_d;

   always_comb
   begin
      status_d = srls_pkg::LINK_STATUS_RESET;
      status_d[srls_pkg::GROUP_LOCKED_BIT] = laneIn.groupLocked;
      status_d[srls_pkg::FRAME_LOCKED_BIT] = laneIn.frameLocked;
      status_d[srls_pkg::SUM_MATCH_BIT] = laneIn.sumMatch;
      status_d[srls_pkg::ALIGN_SYNC_BIT] = laneIn.alignmentSyncOk;
      status_d[srls_pkg::DESKEW_OK_BIT] = laneIn.deskewOk;
      status_d[srls_pkg::STRAY_CTRL_BIT] =
         overLimit(laneIn.strayControlCount, errorCountLimit);
      status_d[srls_pkg::BAD_SYMBOL_BIT] =
         overLimit(laneIn.badSymbolCount, errorCountLimit);
      status_d[srls_pkg::DISPARITY_BIT] =
         overLimit(laneIn.disparityCount, errorCountLimit);
   end

   // Tracks live state every cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         status_q <= srls_pkg::LINK_STATUS_RESET;
      else
         status_q <= status_d;
   end

endmodule // srls_lane_status

// file: rtl/srls_reg_decode.sv
// Address decode for the lane status registers.
// Assumes the register port presents a full 12-bit address.
`timescale 1ns/10ps
module srls_reg_decode
(
   // Request
   input wire logic [11:0] addr,
   // Decode result
   output logic hit,
   output logic [1:0] laneIdx
);

   always_comb
   begin
      hit = 1'b1;
      laneIdx = 2'h0;
      case (addr)
         srls_pkg::LANE2_LINK_STATUS_ADDR: laneIdx = 2'h0;
         srls_pkg::LANE3_LINK_STATUS_ADDR: laneIdx = 2'h1;
         srls_pkg::LANE4_LINK_STATUS_ADDR: laneIdx = 2'h2;
         default: hit = 1'b0;
      endcase
   end

endmodule // srls_reg_decode

// file: testbench/srls_tb_pkg.sv
// Reference status byte for one lane.
// Used by the checker and the bench.
package srls_tb_pkg;
   function automatic logic [7:0] st(srls_pkg::srls_lane_in_s l,
      logic [7:0] m);
      return {l.disparityCount >= m, l.badSymbolCount >= m,
         l.strayControlCount >= m, l.deskewOk, l.alignmentSyncOk,
         l.sumMatch, l.frameLocked, l.groupLocked};
   endfunction
endpackage

// file: testbench/srls_link_status_monitor.sv
// Read-port checker for the lane status block.
// Sees only the top ports.
`timescale 1ns/10ps
module srls_link_status_monitor
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Lane side
   input srls_pkg::srls_lane_in_s [2:0] laneIn,
   input wire logic [7:0] errorCountLimit,
   // Read port
   input srls_pkg::srls_rd_req_s rdReq,
   input wire logic [7:0] rdData_q,
   input wire logic rdValid_q,
   input wire logic rdHit_q
);
   srls_pkg::srls_lane_in_s [2:0] p1, p2;
   logic [7:0] m1, m2;
   // Reset level one edge before a read: images still at reset
   logic r1, r2;
   wire logic rd = rdReq.rdEn;
   wire logic [11:0] a = rdReq.addr;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Inputs a read answer reflects
   always_ff @(posedge clk)
   begin
      p1 <= laneIn;
      p2 <= p1;
      m1 <= errorCountLimit;
      m2 <= m1;
      r1 <= rst_n;
      r2 <= r1;
   end
   a_read_answer: assert property (rd |=> rdValid_q)
      else $error("read not answered");
   a_valid_cause: assert property (!rd |=> !rdValid_q)
      else $error("valid without read");
   a_hit_pulse: assert property (rdHit_q |-> rdValid_q)
      else $error("hit without valid");
   a_unmapped_zero: assert property (rd && (a < 12'h04B2 ||
      a > 12'h04B4) |=> !rdHit_q && rdData_q == 8'h00)
      else $error("unmapped read");
   a_lane2_byte: assert property (rd && a == 12'h04B2
      |=> rdHit_q && rdData_q ==
      (r2 ? srls_tb_pkg::st(p2[0], m2) : 8'h00))
      else $error("lane 2 byte");
   a_lane3_byte: assert property (rd && a == 12'h04B3
      |=> rdHit_q && rdData_q ==
      (r2 ? srls_tb_pkg::st(p2[1], m2) : 8'h00))
      else $error("lane 3 byte");
   a_lane4_byte: assert property (rd && a == 12'h04B4
      |=> rdHit_q && rdData_q ==
      (r2 ? srls_tb_pkg::st(p2[2], m2) : 8'h00))
      else $error("lane 4 byte");
   a_data_holds: assert property (!rd |=> $stable(rdData_q))
      else $error("read data moved");
endmodule // srls_link_status_monitor
bind srls_link_status srls_link_status_monitor srls_link_status_monitor_i
   (.clk, .rst_n, .laneIn, .errorCountLimit, .rdReq, .rdData_q,
   .rdValid_q, .rdHit_q);

// file: testbench/srls_lane_src.sv
// Far-end lane state: flags and counts as the receiver sees them.
// New random state on hop; counts straddle the limit.
`timescale 1ns/10ps
module srls_lane_src
(
   // Clock and control
   input wire logic clk,
   input wire logic hop,
   input wire logic [7:0] lim,
   // Lane state
   output srls_pkg::srls_lane_in_s [2:0] laneIn
);
   initial laneIn = '0;
   always @(posedge clk)
   begin
      if (hop)
      begin
         for (int i = 0; i < 3; i++)
         begin
            // All five flags drawn at random, so any sync flag can be clear
            laneIn[i][28:24] <= 5'($urandom);
            for (int j = 0; j < 3; j++)
               laneIn[i][8*j +: 8] <= lim + 8'($urandom % 3) - 8'h01;
         end
      end
   end
endmodule // srls_lane_src

// file: testbench/srls_link_status_test.sv
// Random lane states, every lane address and three unmapped ones read and modelled.
// Reads start two edges after a lane change.
`timescale 1ns/10ps
module srls_link_status_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hop = 1'b0;
   logic [7:0] lim = 8'h00;
   srls_pkg::srls_lane_in_s [2:0] lane;
   srls_pkg::srls_rd_req_s req = '0;
   logic [7:0] rdData_q;
   logic rdValid_q;
   logic rdHit_q;
   int error_cnt = 0;
   int total_checks = 0;
   logic [11:0] adr[$] = '{12'h04B2, 12'h04B3, 12'h04B3, 12'h04B4,
      12'h04B1, 12'h04B5, 12'h0000};
   initial forever #10 clk = ~clk;
   srls_lane_src srls_lane_src_i (.clk, .hop, .lim, .laneIn(lane));
   srls_link_status srls_link_status_i (.clk, .rst_n, .laneIn(lane),
      .errorCountLimit(lim), .rdReq(req), .rdData_q, .rdValid_q,
      .rdHit_q);
   task chk(logic [9:0] got, logic [9:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task end_sim;
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task rd(logic [11:0] a);
      logic h;
      logic [7:0] e;
      h = a >= 12'h04B2 && a <= 12'h04B4;
      e = h ? srls_tb_pkg::st(lane[a - 12'h04B2], lim) : 8'h00;
      @(posedge clk) #1 req <= {1'b1, a};
      @(posedge clk) #1 req.rdEn <= 1'b0;
      chk({rdValid_q, rdHit_q, rdData_q}, {1'b1, h, e});
   endtask
   initial
   begin
      void'($urandom(32'h0c03));
      repeat (16) @(posedge clk);
      chk({rdValid_q, rdHit_q, rdData_q}, 10'h000);
      #1 rst_n = 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(posedge clk) #1 lim <= n < 2 ? {8{n[0]}} : 8'($urandom);
         hop <= 1'b1;
         @(posedge clk) #1 hop <= 1'b0;
         foreach (adr[k]) rd(adr[k]);
      end
      // Mid-run reset; a read at the first edge sees reset images
      @(posedge clk) #1 rst_n = 1'b0;
      lim <= 8'h00;
      @(posedge clk) #1 chk({rdValid_q, rdHit_q, rdData_q}, 10'h000);
      req <= {1'b1, 12'h04B3};
      rst_n = 1'b1;
      @(posedge clk) #1 req.rdEn <= 1'b0;
      chk({rdValid_q, rdHit_q, rdData_q}, {2'b11, 8'h00});
      rd(12'h04B3);
      end_sim;
   end
   initial
   begin
      #50us;
      error_cnt++;
      end_sim;
   end
endmodule // srls_link_status_test
